/* File: rtl/pfss_pkg.sv */
// Package of the fault source selector for the third modulator channel.
// Assumes a 32-bit Avalon-MM register slave on clk_sys.
package pfss_pkg;

   localparam logic [31:0] PFSS_CLIM_ADDR  = 32'h00130064;
   localparam logic [31:0] PFSS_ABFLT_ADDR = 32'h00130068;
   localparam logic [15:0] PFSS_CLIM_RESET  = 16'h0000;
   localparam logic [14:0] PFSS_ABFLT_RESET = 15'h0000;
   localparam int PFSS_PCM_BIT   = 15;
   localparam int PFSS_DCMP_LSB  = 11;
   localparam int PFSS_PIN_LSB   = 7;
   localparam int PFSS_ACMP_LSB  = 0;
   localparam int PFSS_SYNC_DEPTH = 2;

   // Sources in register bit order: digital 3..0, pins 3..0, analog G..A.
   typedef struct packed {
      logic [3:0] digital_cmp;
      logic [3:0] ext_pin;
      logic [6:0] analog_cmp;
   } pfss_src_t;

   typedef struct packed {
      logic [15:0] current_limit_source_enable_reg;
      logic [14:0] ab_fault_source_enable_reg;
      logic [31:0] readdata_reg;
      logic        readdatavalid_reg;
      logic        current_limit_reg;
      logic        ab_fault_reg;
   } pfss_state_t;

endpackage : pfss_pkg

/* File: rtl/pfss_sync.sv */
// Two-stage synchroniser for asynchronous pin levels.
// Assumes a single clock; the first stage feeds only the second.
`timescale 1ns/1ps
module pfss_sync #(
   parameter int WIDTH = 4
) (
   input  wire logic             clk_sys,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } pfss_sync_state_t;

   pfss_sync_state_t state_reg;
   pfss_sync_state_t state_next;

   // Only the second stage leaves the module, so a metastable first stage
   // never reaches the selection logic.
   always_comb begin
      state_next.meta   = async_in;
      state_next.stable = state_reg.meta;
   end

   assign sync_out = state_reg.stable;

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end
endmodule : pfss_sync

/* File: rtl/pfss_top.sv */
// Source selection for current-limit and combined A/B fault paths.
// Assumes comparator results are on clk_sys; fault pins are asynchronous.
`timescale 1ns/1ps

// How it works
// R1 - Bit 15 of current-limit enables gate the analog peak-current result.
// R2 - Current-limit bits 14..11 gate digital comparators 3..0.
// R3 - Current-limit bits 10..7 gate external fault pins 3..0.
// R4 - Current-limit bits 6..0 gate analog comparators G..A.
// R5 - A/B fault bits 14..11 gate digital comparators 3..0.
// R6 - A/B fault bits 10..7 gate external fault pins 3..0.
// R7 - A/B fault bits 6..0 gate analog comparators G..A.
// R8 - Current-limit enable register resets to zero.
// R9 - A/B fault enable register resets to zero.
// R10 - Each path is the OR of its enabled active sources.
module pfss_top (
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   input  wire logic [31:0] avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_readdatavalid,
   output logic             avs_waitrequest,
   input  wire logic        analog_peak_current,
   input  wire logic [3:0]  digital_cmp,
   input  wire logic [3:0]  ext_fault_pin,
   input  wire logic [6:0]  analog_cmp,
   output logic             current_limit,
   output logic             ab_fault
);

   ////////////////////////////////////////////////////////////////////////
   // Field view of the current-limit enables, most significant bit first.
   typedef struct packed {
      logic analog_peak_source_enable;
      logic digital_cmp3_source_enable;
      logic digital_cmp2_source_enable;
      logic digital_cmp1_source_enable;
      logic digital_cmp0_source_enable;
      logic ext_pin3_source_enable;
      logic ext_pin2_source_enable;
      logic ext_pin1_source_enable;
      logic ext_pin0_source_enable;
      logic analog_cmp_g_source_enable;
      logic analog_cmp_f_source_enable;
      logic analog_cmp_e_source_enable;
      logic analog_cmp_d_source_enable;
      logic analog_cmp_c_source_enable;
      logic analog_cmp_b_source_enable;
      logic analog_cmp_a_source_enable;
   } pfss_clim_view_t;

   // Field view of the pair fault enables, most significant bit first.
   typedef struct packed {
      logic digital_cmp3_source_enable;
      logic digital_cmp2_source_enable;
      logic digital_cmp1_source_enable;
      logic digital_cmp0_source_enable;
      logic ext_pin3_source_enable;
      logic ext_pin2_source_enable;
      logic ext_pin1_source_enable;
      logic ext_pin0_source_enable;
      logic analog_cmp_g_source_enable;
      logic analog_cmp_f_source_enable;
      logic analog_cmp_e_source_enable;
      logic analog_cmp_d_source_enable;
      logic analog_cmp_c_source_enable;
      logic analog_cmp_b_source_enable;
      logic analog_cmp_a_source_enable;
   } pfss_abflt_view_t;

   // Which register a bus address selects.
   typedef enum logic [1:0] {
      PFSS_SEL_NONE,
      PFSS_SEL_CLIM,
      PFSS_SEL_ABFLT
   } pfss_sel_t;

   pfss_pkg::pfss_state_t state_reg;
   pfss_pkg::pfss_state_t state_next;
   pfss_pkg::pfss_src_t   src;
   logic [3:0]            pin_sync;
   pfss_clim_view_t       clim_view;
   pfss_abflt_view_t      abflt_view;
   logic [14:0]           clim_src_en;
   logic [14:0]           abflt_src_en;
   logic                  peak_hit;
   logic                  bus_read_wait;
   pfss_sel_t             bus_sel;

   // Pins arrive from outside the clock domain.
   pfss_sync #(
      .WIDTH    (4)
   ) u_pin_sync (
      .clk_sys  (clk_sys),
      .reset_n  (reset_n),
      .async_in (ext_fault_pin),
      .sync_out (pin_sync)
   );

   ////////////////////////////////////////////////////////////////////////
   // Merges a write with byte enables into a stored value.
   function automatic logic [31:0] pfss_merge(
      input logic [31:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0]  be
   );
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction : pfss_merge

   // Enabled sources only; a disabled source is masked whatever its level.
   function automatic logic [14:0] pfss_gate(
      input logic [14:0]         en,
      input pfss_pkg::pfss_src_t s
   );
      return en & s;
   endfunction : pfss_gate

   // Any enabled and active source asserts the path.
   function automatic logic pfss_any(
      input logic [14:0]         en,
      input pfss_pkg::pfss_src_t s
   );
      return |pfss_gate(en, s); // see R10
   endfunction : pfss_any

   // Decodes a full byte address; every other address selects nothing.
   function automatic pfss_sel_t pfss_decode(
      input logic [31:0] addr
   );
      pfss_sel_t sel;
      sel = PFSS_SEL_NONE;
      if (addr == pfss_pkg::PFSS_CLIM_ADDR) begin
         sel = PFSS_SEL_CLIM;
      end else if (addr == pfss_pkg::PFSS_ABFLT_ADDR) begin
         sel = PFSS_SEL_ABFLT;
      end
      return sel;
   endfunction : pfss_decode

   ////////////////////////////////////////////////////////////////////////
   // Lines the current-limit enables up with the source word.
   // The peak-current bit is left out; it has a gate of its own.
   function automatic logic [14:0] pfss_clim_sources(
      input pfss_clim_view_t v
   );
      return {
         v.digital_cmp3_source_enable, // see R2
         v.digital_cmp2_source_enable,
         v.digital_cmp1_source_enable,
         v.digital_cmp0_source_enable,
         v.ext_pin3_source_enable, // see R3
         v.ext_pin2_source_enable,
         v.ext_pin1_source_enable,
         v.ext_pin0_source_enable,
         v.analog_cmp_g_source_enable, // see R4
         v.analog_cmp_f_source_enable,
         v.analog_cmp_e_source_enable,
         v.analog_cmp_d_source_enable,
         v.analog_cmp_c_source_enable,
         v.analog_cmp_b_source_enable,
         v.analog_cmp_a_source_enable
      };
   endfunction : pfss_clim_sources

   // Lines the pair fault enables up with the source word.
   // This path has no peak-current input at all.
   function automatic logic [14:0] pfss_abflt_sources(
      input pfss_abflt_view_t v
   );
      return {
         v.digital_cmp3_source_enable, // see R5
         v.digital_cmp2_source_enable,
         v.digital_cmp1_source_enable,
         v.digital_cmp0_source_enable,
         v.ext_pin3_source_enable, // see R6
         v.ext_pin2_source_enable,
         v.ext_pin1_source_enable,
         v.ext_pin0_source_enable,
         v.analog_cmp_g_source_enable, // see R7
         v.analog_cmp_f_source_enable,
         v.analog_cmp_e_source_enable,
         v.analog_cmp_d_source_enable,
         v.analog_cmp_c_source_enable,
         v.analog_cmp_b_source_enable,
         v.analog_cmp_a_source_enable
      };
   endfunction : pfss_abflt_sources

   // Builds the read word; bits above a register's width read as zero.
   function automatic logic [31:0] pfss_read_word(
      input pfss_sel_t   sel,
      input logic [15:0] clim,
      input logic [14:0] abflt
   );
      logic [31:0] word;
      word = 32'h00000000;
      unique case (sel)
         PFSS_SEL_CLIM: begin
            word = {16'h0000, clim};
         end
         PFSS_SEL_ABFLT: begin
            word = {17'h00000, abflt};
         end
         default: begin
            word = 32'h00000000;
         end
      endcase
      return word;
   endfunction : pfss_read_word

   ////////////////////////////////////////////////////////////////////////
   // Sources in register bit order, and the enables as the same word.
   // Pins enter only through the synchroniser.
   assign src          = {digital_cmp, pin_sync, analog_cmp};
   assign clim_view    = state_reg.current_limit_source_enable_reg;
   assign abflt_view   = state_reg.ab_fault_source_enable_reg;
   assign clim_src_en  = pfss_clim_sources(clim_view);
   assign abflt_src_en = pfss_abflt_sources(abflt_view);
   assign bus_sel      = pfss_decode(avs_address);

   // The peak-current result feeds the current limit only.
   assign peak_hit = clim_view.analog_peak_source_enable
                     & analog_peak_current; // see R1

   // A read waits one cycle so its word comes from a register; the
   // completion flag doubles as readdatavalid. Writes never wait.
   assign bus_read_wait     = avs_read & ~state_reg.readdatavalid_reg;
   assign avs_waitrequest   = bus_read_wait;
   assign avs_readdata      = state_reg.readdata_reg;
   assign avs_readdatavalid = state_reg.readdatavalid_reg;
   assign current_limit     = state_reg.current_limit_reg;
   assign ab_fault          = state_reg.ab_fault_reg;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [31:0] merged;
      merged = 32'h00000000;
      state_next = state_reg;
      // The flag drops right after a completed read, so a back-to-back
      // read waits again.
      state_next.readdatavalid_reg = bus_read_wait;
      if (bus_read_wait) begin
         // Unmapped addresses read as zero.
         state_next.readdata_reg = pfss_read_word(bus_sel,
            state_reg.current_limit_source_enable_reg,
            state_reg.ab_fault_source_enable_reg);
      end
      if (avs_write) begin
         // Writes to unmapped addresses are dropped.
         unique case (bus_sel)
            PFSS_SEL_CLIM: begin
               merged = pfss_merge(
                  {16'h0000, state_reg.current_limit_source_enable_reg},
                  avs_writedata, avs_byteenable);
               state_next.current_limit_source_enable_reg = merged[15:0];
            end
            PFSS_SEL_ABFLT: begin
               merged = pfss_merge(
                  {17'h00000, state_reg.ab_fault_source_enable_reg},
                  avs_writedata, avs_byteenable);
               // Bit 15 is reserved and stays zero.
               state_next.ab_fault_source_enable_reg = merged[14:0];
            end
            default: begin
               merged = 32'h00000000;
            end
         endcase
      end
      // Registered outputs cost one cycle but give glitch-free levels.
      // A new enable acts from the cycle after the write.
      state_next.current_limit_reg = peak_hit // see R1
         | pfss_any(clim_src_en, src); // see R2 R3 R4 R10
      state_next.ab_fault_reg = pfss_any(abflt_src_en, src); // see R5 R6 R7
   end

   ////////////////////////////////////////////////////////////////////////
   // Reset also clears the read flag, so no stale answer follows it.

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         state_reg <= '0;
         state_reg.current_limit_source_enable_reg <=
            pfss_pkg::PFSS_CLIM_RESET; // see R8
         state_reg.ab_fault_source_enable_reg <=
            pfss_pkg::PFSS_ABFLT_RESET; // see R9
      end else begin
         state_reg <= state_next;
      end
   end

endmodule : pfss_top

/* File: tb/pfss_monitor.sv */
// Port checker for the fault source selector.
// Bound to pfss_top; sees its ports only.
`timescale 1ns/1ps
module pfss_monitor (
   input wire logic        clk_sys,
   input wire logic        reset_n,
   input wire logic [31:0] avs_address,
   input wire logic        avs_read,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_readdatavalid,
   input wire logic        avs_waitrequest,
   input wire logic        analog_peak_current,
   input wire logic [3:0]  digital_cmp,
   input wire logic [3:0]  ext_fault_pin,
   input wire logic [6:0]  analog_cmp,
   input wire logic        current_limit,
   input wire logic        ab_fault
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   a_clim_rst:
      assert property (disable iff (1'b0) !reset_n |=> !current_limit)
      else $error("current limit set in reset");
   a_ab_rst:
      assert property (disable iff (1'b0) !reset_n |=> !ab_fault)
      else $error("pair fault set in reset");
   a_quiet_src:
      assert property ((digital_cmp == 4'h0 && analog_cmp == 7'h00 &&
         !analog_peak_current && ext_fault_pin == 4'h0) [*4]
         |=> !current_limit && !ab_fault) else $error("fault with no source");
   a_read_valid:
      assert property (avs_read && avs_waitrequest |=> avs_readdatavalid
         && !avs_waitrequest) else $error("read not answered");
   a_no_valid:
      assert property (!avs_read |=> !avs_readdatavalid)
      else $error("stray read answer");
   a_unmapped_zero:
      assert property (avs_read && !avs_waitrequest
         && avs_address != pfss_pkg::PFSS_CLIM_ADDR
         && avs_address != pfss_pkg::PFSS_ABFLT_ADDR
         |-> avs_readdata == 32'h00000000)
      else $error("unmapped read not zero");
   a_read_rst:
      assert property ($past(!reset_n, 2) && avs_read && !avs_waitrequest
         |-> avs_readdata == 32'h00000000)
      else $error("enables not clear after reset");
   a_ab_upper:
      assert property (avs_read && !avs_waitrequest
         && avs_address == pfss_pkg::PFSS_ABFLT_ADDR
         |-> avs_readdata[31:15] == 17'h00000) else $error("reserved bits");
endmodule : pfss_monitor
bind pfss_top pfss_monitor u_mon (.*);

/* File: tb/pfss_src_model.sv */
// Model of the comparators and fault pins ahead of the selector.
// Takes the wanted source levels in register bit order.
`timescale 1ns/1ps
module pfss_src_model (
   input  wire logic        clk_sys,
   input  wire logic [15:0] want,
   output logic             analog_peak_current,
   output logic [3:0]       digital_cmp,
   output logic [3:0]       ext_fault_pin,
   output logic [6:0]       analog_cmp
);
   always_ff @(posedge clk_sys) begin
      {analog_peak_current, digital_cmp, ext_fault_pin, analog_cmp} <= want;
   end
endmodule : pfss_src_model

/* File: tb/tb.sv */
// Self-checking bench for the fault source selector.
// Assumes pfss_top with its bound checker and a 100 MHz clk_sys.
`timescale 1ns/1ps
module tb;
   logic clk_sys, reset_n, avs_read, avs_write, avs_readdatavalid;
   logic avs_waitrequest, analog_peak_current, current_limit, ab_fault;
   logic [31:0] avs_address, avs_writedata, avs_readdata, r;
   logic [3:0]  avs_byteenable, digital_cmp, ext_fault_pin;
   logic [6:0]  analog_cmp;
   logic [15:0] want, cl_en, ab_en;
   logic [31:0] lfsr = 32'h3af156b3;
   int bad_count = 0, checks = 0, cyc = 0;
   pfss_top uut (.clk_sys, .reset_n, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_readdatavalid,
      .avs_waitrequest, .analog_peak_current, .digital_cmp, .ext_fault_pin,
      .analog_cmp, .current_limit, .ab_fault);
   pfss_src_model u_src (.clk_sys, .want, .analog_peak_current,
      .digital_cmp, .ext_fault_pin, .analog_cmp);
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction : rnd
   function automatic logic [15:0] mrg(logic [15:0] o, n, logic [3:0] b);
      return {b[1] ? n[15:8] : o[15:8], b[0] ? n[7:0] : o[7:0]};
   endfunction : mrg
   task chk(input logic [32:0] g, e);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task wr(input logic [31:0] a, d, input logic [3:0] b);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= b;
      avs_write <= 1'b1;
      @(negedge clk_sys);
      while (avs_waitrequest !== 1'b0) @(negedge clk_sys);
      @(posedge clk_sys);
      avs_write <= 1'b0;
      @(posedge clk_sys);
   endtask : wr
   task rd(input logic [31:0] a, e);
      logic [32:0] got;
      avs_address <= a;
      avs_read <= 1'b1;
      @(negedge clk_sys);
      while (avs_waitrequest !== 1'b0) @(negedge clk_sys);
      got = {avs_readdatavalid, avs_readdata};
      @(posedge clk_sys);
      avs_read <= 1'b0;
      chk(got, {1'b1, e});
      @(posedge clk_sys);
   endtask : rd
   task setr(input logic [15:0] c, a, input logic [3:0] b);
      wr(pfss_pkg::PFSS_CLIM_ADDR, {16'h0000, c}, b);
      wr(pfss_pkg::PFSS_ABFLT_ADDR, {16'h0000, a}, b);
      cl_en = mrg(cl_en, c, b);
      ab_en = mrg(ab_en, a, b) & 16'h7fff;
   endtask : setr
   task src_chk(input logic [15:0] w);
      want <= w;
      repeat (6) @(posedge clk_sys);
      @(negedge clk_sys);
      chk({current_limit, ab_fault}, {|(w & cl_en), |(w & ab_en)});
      @(posedge clk_sys);
   endtask : src_chk
   task test_done();
      $display("Mismatches %0d, checks %0d", bad_count, checks);
      if (bad_count == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : test_done
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         test_done();
      end
   end
   initial begin
      {reset_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
      {avs_byteenable, want, cl_en, ab_en} = '0;
      repeat (12) @(posedge clk_sys);
      reset_n <= 1'b1;
      rd(pfss_pkg::PFSS_CLIM_ADDR, 32'h0);
      rd(pfss_pkg::PFSS_ABFLT_ADDR, 32'h0);
      rd(32'h0013006c, 32'h0);
      for (int i = 0; i < 16; i++) begin
         setr(16'h1 << i, 16'h1 << i, 4'hf);
         src_chk(16'h1 << i);
         src_chk(~(16'h1 << i));
      end
      repeat (40) begin
         r = rnd();
         setr(r[15:0], r[31:16], r[7:4]);
         rd(pfss_pkg::PFSS_CLIM_ADDR, {16'h0000, cl_en});
         rd(pfss_pkg::PFSS_ABFLT_ADDR, {16'h0000, ab_en});
         src_chk(16'(rnd() & rnd()));
      end
      reset_n <= 1'b0;
      cl_en = 16'h0000;
      ab_en = 16'h0000;
      repeat (3) @(posedge clk_sys);
      reset_n <= 1'b1;
      rd(pfss_pkg::PFSS_CLIM_ADDR, 32'h0);
      rd(pfss_pkg::PFSS_ABFLT_ADDR, 32'h0);
      src_chk(16'hffff);
      test_done();
   end
endmodule : tb
